// ---- hw/ocr_pkg.sv ----
// Purpose: shared constants and carrier types for optical clock rate negotiation
// Assumes: clock rates are indexed 0 (lowest) upward; each index a fixed multiple of the one below
// Notes: no software registers; all control arrives on plain ports
package ocr_pkg;

  localparam int RATE_W = 3;
  localparam int DRATE_W = 3;
  localparam int PEER_W = 3;
  localparam logic [RATE_W-1:0] LOWEST_RATE = 3'h0;
  localparam logic [DRATE_W-1:0] LOWEST_DRATE = 3'h0;
  localparam logic [RATE_W-1:0] RST_MAX_RATE = 3'h0;
  localparam int RATE_MULT = 2;

  typedef enum logic [2:0] {
    OCR_FR_DATA = 3'b000,
    OCR_FR_ASSOC_REQ = 3'b001,
    OCR_FR_ASSOC_GRANT = 3'b010,
    OCR_FR_RATE_NOTIFY = 3'b011,
    OCR_FR_BEACON = 3'b100,
    OCR_FR_CAP_UPLINK = 3'b101
  } ocr_frame_t;

  // Capability element content
  typedef struct packed {
    logic [RATE_W-1:0] max_transmit_clock;
    logic [RATE_W-1:0] max_receive_clock;
    logic explicit_neg;
  } ocr_cap_t;

  // Per-frame rate choice handed to the transmit path
  typedef struct packed {
    ocr_frame_t kind;
    logic [PEER_W-1:0] peer;
    logic [RATE_W-1:0] clock_rate;
    logic [DRATE_W-1:0] header_drate;
    logic [DRATE_W-1:0] payload_drate;
    ocr_cap_t cap;
  } ocr_tx_t;

  // Incoming capability or notification from a peer
  typedef struct packed {
    ocr_frame_t kind;
    logic [PEER_W-1:0] peer;
    logic [RATE_W-1:0] rate;
    ocr_cap_t cap;
  } ocr_rx_t;

endpackage : ocr_pkg

// ---- hw/ocr_min_rate.sv ----
// Purpose: smaller of two rate indices, and a requested index clipped to that smaller one
// Assumes: indices ordered lowest first
// Notes: purely combinational
`timescale 1ns/1ps
module ocr_min_rate #(
  parameter int W = 3
) (
  input wire logic [W-1:0] i_a,
  input wire logic [W-1:0] i_b,
  input wire logic [W-1:0] i_want,
  output logic [W-1:0] o_cap,
  output logic [W-1:0] o_sel
);
  always_comb begin
    o_cap = (i_a < i_b) ? i_a : i_b;
    o_sel = (i_want > o_cap) ? o_cap : i_want;
  end
endmodule : ocr_min_rate

// ---- hw/ocr_negotiator.sv ----
// Purpose: clock and data rate selection and negotiation for an optical link end
// Assumes: framing layer moves one frame per o_tx_valid/i_tx_ready handshake
// Notes: peers tracked by small index; entries revert to the lowest rate until negotiated
// Functional notes
// - Lowest clock rate of the PHY type is always supported, transmit and receive.
// - Every defined rate below the supported maximum is supported too.
// - Every data rate of a supported clock rate is supported.
// - Preamble, headers and payload of one frame share one clock rate.
// - Header goes at the lowest data rate of the frame's clock.
// - Payload may use any data rate of the frame's clock.
// - With explicit negotiation, notify a rate change before using it.
// - Without negotiation, receiver synchronises at every supported rate blindly.
// - Each rate is an integer multiple of the next lower one.
// - Association request goes at lowest clock, carrying max transmit and receive clocks.
// - Association request holds the capabilities element.
// - Coordinator selection not above min of own transmit max and peer receive max.
// - Association grant returned at the lowest clock rate.
// - After association, notify selected rates before switching to them.
// - Later transmit rate changes stay within the permitted maximum.
// - Star coordinator broadcasts its capabilities in a beacon.
// - Contention period uplink always uses the lowest clock rate.
// - Star selections are exchanged at lowest clock before switching.
// - Current clock and every change are announced by notification; with i_explicit_neg low the code applies changes without one.
`timescale 1ns/1ps
module ocr_negotiator #(
  parameter int NPEER = 8,
  parameter logic [ocr_pkg::RATE_W-1:0] OWN_MAX_TX = 3'h3,
  parameter logic [ocr_pkg::RATE_W-1:0] OWN_MAX_RX = 3'h3,
  parameter logic [ocr_pkg::DRATE_W-1:0] DRATES_PER_CLOCK = 3'h4
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_is_coord,
  input wire logic i_explicit_neg,
  input wire logic i_assoc_start,
  input wire logic i_beacon_start,
  input wire logic i_cap_uplink,
  input wire logic i_mcast_start,
  input wire logic [NPEER-1:0] i_mcast_mask,
  input wire logic i_change_req,
  input wire logic [ocr_pkg::PEER_W-1:0] i_change_peer,
  input wire logic [ocr_pkg::RATE_W-1:0] i_change_rate,
  input wire logic i_data_req,
  input wire logic [ocr_pkg::PEER_W-1:0] i_data_peer,
  input wire logic [ocr_pkg::DRATE_W-1:0] i_data_drate,
  input wire logic i_rx_valid,
  input wire ocr_pkg::ocr_rx_t i_rx,
  input wire logic i_tx_ready,
  output ocr_pkg::ocr_tx_t o_tx,
  output logic o_tx_valid,
  output logic o_busy,
  output logic o_rx_hunt,
  output logic [ocr_pkg::RATE_W-1:0] o_rx_rate,
  output logic [ocr_pkg::RATE_W-1:0] o_tx_div
);

  typedef enum logic [1:0] {
    OCR_IDLE = 2'b00,
    OCR_SEND = 2'b01
  } ocr_state_t;

  localparam int PW = ocr_pkg::PEER_W;
  localparam int RW = ocr_pkg::RATE_W;

  ////////////////////////////////////////////////////////////////////////
  // Per-peer tables
  logic [RW-1:0] cur_rate [NPEER];
  logic [RW-1:0] max_rate [NPEER];
  logic [NPEER-1:0] known;
  logic [RW-1:0] pend_rate [NPEER];
  logic [NPEER-1:0] pend;
  logic [RW-1:0] next_cur_rate [NPEER];
  logic [RW-1:0] next_max_rate [NPEER];
  logic [NPEER-1:0] next_known;
  logic [RW-1:0] next_pend_rate [NPEER];
  logic [NPEER-1:0] next_pend;

  ocr_state_t state;
  ocr_state_t next_state;
  ocr_pkg::ocr_tx_t tx;
  ocr_pkg::ocr_tx_t next_tx;
  logic tx_valid;
  logic next_tx_valid;
  logic rx_hunt;
  logic next_rx_hunt;
  logic [RW-1:0] rx_rate;
  logic [RW-1:0] next_rx_rate;
  logic [RW-1:0] tx_div;
  logic [RW-1:0] next_tx_div;

  logic [RW-1:0] own_tx_max;
  logic [RW-1:0] own_rx_max;
  logic [RW-1:0] assoc_cap;
  logic [RW-1:0] assoc_sel;
  logic [RW-1:0] chg_cap;
  logic [RW-1:0] chg_sel;
  logic [RW-1:0] mcast_rate;
  logic [RW-1:0] rx_peer_max;
  logic [ocr_pkg::DRATE_W-1:0] drate_top;

  assign own_tx_max = OWN_MAX_TX;
  assign own_rx_max = OWN_MAX_RX;
  assign rx_peer_max = i_rx.cap.max_receive_clock;
  assign drate_top = DRATES_PER_CLOCK - 3'h1;

  ocr_min_rate #(.W(RW)) u_assoc_min (
    .i_a(own_tx_max),
    .i_b(rx_peer_max),
    .i_want(rx_peer_max),
    .o_cap(assoc_cap),
    .o_sel(assoc_sel)
  );

  ocr_min_rate #(.W(RW)) u_chg_min (
    .i_a(own_tx_max),
    .i_b(max_rate[i_change_peer]),
    .i_want(i_change_rate),
    .o_cap(chg_cap),
    .o_sel(chg_sel)
  );

  always_comb begin
    mcast_rate = own_tx_max;
    for (int p = 0; p < NPEER; p++) begin
      if (i_mcast_mask[p]) begin
        if (!known[p]) begin
          mcast_rate = ocr_pkg::LOWEST_RATE;
        end else if (max_rate[p] < mcast_rate) begin
          mcast_rate = max_rate[p];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_state = state;
    next_tx = tx;
    next_tx_valid = tx_valid;
    next_known = known;
    next_pend = pend;
    next_rx_hunt = rx_hunt;
    next_rx_rate = rx_rate;
    next_tx_div = tx_div;
    for (int p = 0; p < NPEER; p++) begin
      next_cur_rate[p] = cur_rate[p];
      next_max_rate[p] = max_rate[p];
      next_pend_rate[p] = pend_rate[p];
    end
    next_rx_hunt = !i_explicit_neg;
    unique case (state)
      OCR_IDLE: begin
        next_tx.cap.max_transmit_clock = own_tx_max;
        next_tx.cap.max_receive_clock = own_rx_max;
        next_tx.cap.explicit_neg = i_explicit_neg;
        next_tx.header_drate = ocr_pkg::LOWEST_DRATE;
        next_tx.payload_drate = ocr_pkg::LOWEST_DRATE;
        next_tx.clock_rate = ocr_pkg::LOWEST_RATE;
        if (i_rx_valid && i_rx.kind == ocr_pkg::OCR_FR_ASSOC_REQ && i_is_coord) begin
          next_tx.kind = ocr_pkg::OCR_FR_ASSOC_GRANT;
          next_tx.peer = i_rx.peer;
          next_known[i_rx.peer] = 1'b1;
          next_max_rate[i_rx.peer] = assoc_cap;
          next_cur_rate[i_rx.peer] = ocr_pkg::LOWEST_RATE;
          next_pend[i_rx.peer] = i_explicit_neg;
          next_pend_rate[i_rx.peer] = assoc_sel;
          if (!i_explicit_neg) begin
            next_cur_rate[i_rx.peer] = assoc_sel;
          end
          next_tx_valid = 1'b1;
          next_state = OCR_SEND;
        end else if (i_assoc_start) begin
          next_tx.kind = ocr_pkg::OCR_FR_ASSOC_REQ;
          next_tx.peer = '0;
          next_tx_valid = 1'b1;
          next_state = OCR_SEND;
        end else if (i_beacon_start && i_is_coord) begin
          next_tx.kind = ocr_pkg::OCR_FR_BEACON;
          next_tx.peer = '0;
          next_tx_valid = 1'b1;
          next_state = OCR_SEND;
        end else if (i_cap_uplink) begin
          next_tx.kind = ocr_pkg::OCR_FR_CAP_UPLINK;
          next_tx.peer = i_data_peer;
          next_tx_valid = 1'b1;
          next_state = OCR_SEND;
        end else if (|pend) begin
          for (int p = NPEER - 1; p >= 0; p--) begin
            if (pend[p]) begin
              next_tx.peer = PW'(p);
            end
          end
          next_tx.kind = ocr_pkg::OCR_FR_RATE_NOTIFY;
          next_tx.cap.max_transmit_clock = pend_rate[next_tx.peer];
          next_pend[next_tx.peer] = 1'b0;
          next_cur_rate[next_tx.peer] = pend_rate[next_tx.peer];
          next_tx_valid = 1'b1;
          next_state = OCR_SEND;
        end else if (i_change_req && known[i_change_peer]) begin
          next_pend_rate[i_change_peer] = chg_sel;
          if (i_explicit_neg) begin
            next_pend[i_change_peer] = 1'b1;
          end else begin
            next_cur_rate[i_change_peer] = chg_sel;
          end
        end else if (i_mcast_start) begin
          next_tx.kind = ocr_pkg::OCR_FR_DATA;
          next_tx.peer = '0;
          next_tx.clock_rate = mcast_rate;
          next_tx_valid = 1'b1;
          next_state = OCR_SEND;
        end else if (i_data_req) begin
          next_tx.kind = ocr_pkg::OCR_FR_DATA;
          next_tx.peer = i_data_peer;
          next_tx.clock_rate = known[i_data_peer] ? cur_rate[i_data_peer]
                                                  : ocr_pkg::LOWEST_RATE;
          next_tx.payload_drate = (i_data_drate > drate_top) ? drate_top : i_data_drate;
          next_tx_valid = 1'b1;
          next_state = OCR_SEND;
        end
        if (i_rx_valid && i_rx.kind == ocr_pkg::OCR_FR_RATE_NOTIFY) begin
          // Peer's announced rate, capped at own_rx_max, becomes our expected receive rate
          next_rx_rate = (i_rx.rate > own_rx_max) ? own_rx_max : i_rx.rate;
        end
        if (i_rx_valid && i_rx.kind == ocr_pkg::OCR_FR_ASSOC_GRANT && !i_is_coord) begin
          next_known[i_rx.peer] = 1'b1;
          next_max_rate[i_rx.peer] = (own_tx_max < rx_peer_max) ? own_tx_max : rx_peer_max;
        end
      end
      OCR_SEND: begin
        if (i_tx_ready) begin
          next_tx_valid = 1'b0;
          next_state = OCR_IDLE;
        end
      end
      default: begin
        next_tx_valid = 1'b0;
        next_state = OCR_IDLE;
      end
    endcase
    next_tx_div = own_tx_max - next_tx.clock_rate;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= OCR_IDLE;
      tx <= '0;
      tx_valid <= 1'b0;
      known <= '0;
      pend <= '0;
      rx_hunt <= 1'b0;
      rx_rate <= ocr_pkg::LOWEST_RATE;
      tx_div <= '0;
      for (int p = 0; p < NPEER; p++) begin
        cur_rate[p] <= ocr_pkg::LOWEST_RATE;
        max_rate[p] <= ocr_pkg::RST_MAX_RATE;
        pend_rate[p] <= ocr_pkg::LOWEST_RATE;
      end
    end else begin
      state <= next_state;
      tx <= next_tx;
      tx_valid <= next_tx_valid;
      known <= next_known;
      pend <= next_pend;
      rx_hunt <= next_rx_hunt;
      rx_rate <= next_rx_rate;
      tx_div <= next_tx_div;
      for (int p = 0; p < NPEER; p++) begin
        cur_rate[p] <= next_cur_rate[p];
        max_rate[p] <= next_max_rate[p];
        pend_rate[p] <= next_pend_rate[p];
      end
    end
  end

  assign o_tx = tx;
  assign o_tx_valid = tx_valid;
  // Valid flop mirrors SEND, so busy stays a registered output
  assign o_busy = tx_valid;
  assign o_rx_hunt = rx_hunt;
  assign o_rx_rate = rx_rate;
  assign o_tx_div = tx_div;

endmodule : ocr_negotiator

// ---- verif/ocr_negotiator_chk.sv ----
// Purpose: port assertions for the rate negotiator
// Assumes: one clock domain, async active low reset
// Notes: bound to every negotiator instance
`timescale 1ns/1ps
module ocr_negotiator_chk #(
  parameter logic [ocr_pkg::RATE_W-1:0] OWN_MAX_TX = 3'h3,
  parameter logic [ocr_pkg::DRATE_W-1:0] DRATES_PER_CLOCK = 3'h4
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_explicit_neg,
  input wire logic i_data_req,
  input wire logic i_change_req,
  input wire logic i_tx_ready,
  input wire ocr_pkg::ocr_tx_t o_tx,
  input wire logic o_tx_valid,
  input wire logic o_busy,
  input wire logic o_rx_hunt,
  input wire logic [ocr_pkg::RATE_W-1:0] o_tx_div
);
  ////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_take;
    !o_busy && i_data_req && !i_change_req;
  endsequence
  sequence s_offer;
    o_tx_valid && !i_tx_ready;
  endsequence
  a_req_answer: assert property (s_take |=> o_tx_valid) else $error("request lost");
  a_offer_holds: assert property (s_offer |=> o_tx_valid && $stable(o_tx))
    else $error("frame changed before accept");
  a_valid_drops: assert property (o_tx_valid && i_tx_ready |=> !o_tx_valid)
    else $error("valid held after accept");
  a_header_low: assert property (o_tx_valid |-> o_tx.header_drate == 3'h0)
    else $error("header not at lowest data rate");
  a_payload_range: assert property (o_tx_valid |-> o_tx.payload_drate < DRATES_PER_CLOCK)
    else $error("payload data rate out of range");
  a_lowest_kinds: assert property (o_tx_valid && o_tx.kind inside {ocr_pkg::OCR_FR_ASSOC_REQ,
    ocr_pkg::OCR_FR_ASSOC_GRANT, ocr_pkg::OCR_FR_CAP_UPLINK, ocr_pkg::OCR_FR_RATE_NOTIFY}
    |-> o_tx.clock_rate == 3'h0)
    else $error("control frame above lowest clock");
  a_tx_ceiling: assert property (o_tx_valid |-> o_tx.clock_rate <= OWN_MAX_TX)
    else $error("clock above own maximum");
  a_div_index: assert property (o_tx_valid |-> o_tx_div == OWN_MAX_TX - o_tx.clock_rate)
    else $error("divide index wrong");
  a_hunt_follows: assert property ($past(i_resetn) |-> o_rx_hunt == !$past(i_explicit_neg))
    else $error("hunt mode wrong");
endmodule : ocr_negotiator_chk

bind ocr_negotiator ocr_negotiator_chk #(.OWN_MAX_TX(OWN_MAX_TX),
  .DRATES_PER_CLOCK(DRATES_PER_CLOCK)) ocr_negotiator_chk_i (.i_ref_clk, .i_resetn,
  .i_explicit_neg, .i_data_req, .i_change_req, .i_tx_ready, .o_tx, .o_tx_valid, .o_busy,
  .o_rx_hunt, .o_tx_div);

// ---- verif/ocr_peer_model.sv ----
// Purpose: framing layer and peer that accepts frames
// Assumes: one frame per valid/ready handshake
// Notes: slow mode stalls ready three cycles
`timescale 1ns/1ps
module ocr_peer_model (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire ocr_pkg::ocr_tx_t i_tx,
  input wire logic i_tx_valid,
  input wire logic i_slow,
  output logic o_ready,
  output logic o_took,
  output ocr_pkg::ocr_tx_t o_got
);
  ////////////////////////////////////////
  logic [1:0] waited;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ready <= 1'b0;
      o_took <= 1'b0;
      waited <= 2'h0;
      o_got <= '0;
    end else begin
      o_took <= i_tx_valid && o_ready;
      waited <= (i_tx_valid && !o_ready) ? waited + 2'h1 : 2'h0;
      if (i_tx_valid && o_ready) begin
        o_got <= i_tx;
      end
      o_ready <= i_tx_valid && !o_ready && (!i_slow || waited == 2'h3);
    end
  end
endmodule : ocr_peer_model

// ---- verif/ocr_negotiator_tb_top.sv ----
// Purpose: self-checking bench for the rate negotiator
// Assumes: coordinator role, small own maxima
// Notes: rx summaries driven by the bench
`timescale 1ns/1ps
module ocr_negotiator_tb_top;
  localparam logic [2:0] TXM = 3'h2;
  localparam logic [2:0] RXM = 3'h3;
  localparam logic [2:0] NDR = 3'h4;
  logic i_ref_clk = 0;
  logic i_resetn = 0;
  logic i_is_coord = 1;
  logic i_explicit_neg = 1;
  logic [6:0] pulse = 0;
  wire i_assoc_start = pulse[0];
  wire i_beacon_start = pulse[1];
  wire i_cap_uplink = pulse[2];
  wire i_mcast_start = pulse[3];
  wire i_change_req = pulse[4];
  wire i_data_req = pulse[5];
  wire i_rx_valid = pulse[6];
  logic [7:0] i_mcast_mask = 0;
  logic [2:0] i_change_peer = 0, i_change_rate = 0, i_data_peer = 0, i_data_drate = 0;
  ocr_pkg::ocr_rx_t i_rx = 0;
  ocr_pkg::ocr_tx_t o_tx, got;
  logic i_tx_ready, o_tx_valid, o_busy, o_rx_hunt, slow = 0, took;
  logic [2:0] o_rx_rate, o_tx_div;
  int fails = 0, comparisons = 0, seed = 32'h7d9930da, r, v;
  ////////////////////////////////////////
  ocr_negotiator #(.OWN_MAX_TX(TXM), .OWN_MAX_RX(RXM), .DRATES_PER_CLOCK(NDR)) ocr_negotiator_i (.*);
  ocr_peer_model ocr_peer_model_i (.i_ref_clk, .i_resetn, .i_tx(o_tx), .i_tx_valid(o_tx_valid),
    .i_slow(slow), .o_ready(i_tx_ready), .o_took(took), .o_got(got));
  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  function automatic logic [2:0] clip(input logic [2:0] d);
    return (d > NDR - 1) ? NDR - 1 : d;
  endfunction : clip
  function automatic logic [2:0] lo(input logic [2:0] a, input logic [2:0] b);
    return (a < b) ? a : b;
  endfunction : lo
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task stop_test;
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task fire(input int k);
    @(posedge i_ref_clk);
    #1 pulse = 7'h01 << k;
    v = $random(seed);
    slow = v[0];
    @(posedge i_ref_clk);
    #1 pulse = 0;
    // Released rx summary never keeps its last value
    i_rx = ~i_rx;
  endtask : fire
  task frame(input logic [2:0] kind);
    int n;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      #1 n++;
    end while (took !== 1'b1 && n < 40);
    if (took !== 1'b1) begin
      fails++;
      stop_test();
    end
    check(got.kind, kind);
  endtask : frame
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_ref_clk);
    check({o_tx_valid, o_tx_div, o_rx_rate, o_rx_hunt}, 0);
    #1 i_resetn = 1;
    repeat (2) @(posedge i_ref_clk);
    #1 check(o_rx_hunt, 0);
    for (int j = 0; j < 6; j++) begin
      v = $random(seed);
      i_data_peer = v[2:0];
      i_data_drate = (j == 0) ? 3'h7 : v[5:3];
      fire(5);
      check({o_busy, o_tx_valid, o_tx_div}, {2'b11, TXM});
      frame(ocr_pkg::OCR_FR_DATA);
      check({got.clock_rate, got.header_drate}, 0);
      check(got.payload_drate, clip(i_data_drate));
    end
    fire(0);
    frame(ocr_pkg::OCR_FR_ASSOC_REQ);
    check({got.clock_rate, got.cap.max_transmit_clock, got.cap.max_receive_clock}, {3'h0, TXM, RXM});
    fire(1);
    frame(ocr_pkg::OCR_FR_BEACON);
    check(got.cap.max_transmit_clock, TXM);
    fire(2);
    frame(ocr_pkg::OCR_FR_CAP_UPLINK);
    check(got.clock_rate, 0);
    r = $random(seed);
    i_rx = '{ocr_pkg::OCR_FR_ASSOC_REQ, 3'h5, 3'h0, '{3'h3, r[2:0], 1'b1}};
    fire(6);
    frame(ocr_pkg::OCR_FR_ASSOC_GRANT);
    check(got.clock_rate, 0);
    frame(ocr_pkg::OCR_FR_RATE_NOTIFY);
    check({got.clock_rate, got.cap.max_transmit_clock}, {3'h0, lo(TXM, r[2:0])});
    i_data_peer = 3'h5;
    fire(5);
    frame(ocr_pkg::OCR_FR_DATA);
    check(got.clock_rate, lo(TXM, r[2:0]));
    for (int j = 0; j < 2; j++) begin
      i_change_peer = 3'h5;
      i_change_rate = j ? TXM : 3'h1;
      fire(4);
      frame(ocr_pkg::OCR_FR_RATE_NOTIFY);
      check(got.cap.max_transmit_clock, lo(i_change_rate, lo(TXM, r[2:0])));
      fire(5);
      frame(ocr_pkg::OCR_FR_DATA);
      check(got.clock_rate, lo(i_change_rate, lo(TXM, r[2:0])));
    end
    i_mcast_mask = 8'h24;
    fire(3);
    frame(ocr_pkg::OCR_FR_DATA);
    check(got.clock_rate, 0);
    i_rx = '{ocr_pkg::OCR_FR_RATE_NOTIFY, 3'h5, 3'h7, '0};
    fire(6);
    i_explicit_neg = 0;
    repeat (2) @(posedge i_ref_clk);
    #1 check({o_rx_hunt, o_rx_rate}, {1'b1, RXM});
    i_change_rate = 3'h1;
    fire(4);
    fire(5);
    frame(ocr_pkg::OCR_FR_DATA);
    check(got.clock_rate, lo(3'h1, lo(TXM, r[2:0])));
    stop_test();
  end
endmodule : ocr_negotiator_tb_top
